// [core/flash_prot_defs.svh]
`ifndef FLASH_PROT_DEFS_SVH
`define FLASH_PROT_DEFS_SVH

// Register byte addresses
`define LOCK_OFS 8'h00
`define CTRL_OFS 8'h04
`define STAT_OFS 8'h08
`define PTR_OFS 8'h0c

// Lock field bit positions, 1 = unprogrammed
`define LK_APP_WR 0
`define LK_APP_RD 1
`define LK_BOOT_WR 2
`define LK_BOOT_RD 3
`define LOCK_RST 4'hf

// Control and status bit positions
`define CTRL_IVB 0
`define CTRL_RST 1'h0
`define ST_STORE_DENY 0
`define ST_LOAD_DENY 1
`define ST_PC_BOOT 2
`define ST_RSTFUSE 3
`define ST_SIZE_LO 4

// Reset vector when the boot-reset fuse is unprogrammed
`define APP_RESET_VEC 32'h0000_0000

`endif

// [core/flash_prot_pkg.sv]
package flash_prot_pkg;

    // Which flash section an address falls in
    typedef enum logic {
        SEC_APP,
        SEC_BOOT
    } section_e;

endpackage

// [core/section_decoder.sv]
`timescale 1ns/1ps

module section_decoder
    import flash_prot_pkg::*;
#(
    parameter int WORD_W = 15,
    parameter int BOOT_MIN_WORDS = 512
) (
    input wire logic [WORD_W-1:0] word_addr, // Word address to classify
    input wire logic [1:0] boot_size_fuses, // Boot size selection
    output logic [WORD_W-1:0] boot_start, // First boot word
    output section_e section // Resulting section
);

    logic [WORD_W:0] boot_words;
    logic [WORD_W:0] boundary;

    // Boot size doubles per step down of the fuse code
    always_comb begin
        boot_words = (WORD_W+1)'(BOOT_MIN_WORDS) << (2'd3 - boot_size_fuses);
        boundary = (WORD_W+1)'(1) << WORD_W;
        boundary = boundary - boot_words;
        boot_start = boundary[WORD_W-1:0];
        section = ({1'b0, word_addr} >= boundary) ? SEC_BOOT : SEC_APP;
    end

endmodule

// [core/boot_flash_lock_protection.sv]
// The implementer's own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "flash_prot_defs.svh"

module boot_flash_lock_protection
    import flash_prot_pkg::*;
#(
    parameter int PROG_BYTES = 65536,
    parameter int PAGE_WORD_BITS = 7,
    parameter int BOOT_MIN_WORDS = 512
) (
    input wire logic ref_clk, // System clock
    input wire logic srst, // Synchronous reset, high
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    input wire logic boot_reset_fuse, // Reset vector fuse
    input wire logic [1:0] boot_size_fuses, // Boot size fuses
    input wire logic chip_erase_req, // External chip erase pulse
    input wire logic ext_lock_wr, // External lock program pulse
    input wire logic [3:0] ext_lock_data, // Lock bits, 0 programs
    input wire logic [(PROG_BYTES/2 > 1 ? $clog2(PROG_BYTES/2)-1 : 0):0] pc, // Word PC
    input wire logic [7:0] pointer_low_byte, // Pointer low byte
    input wire logic [7:0] pointer_high_byte, // Pointer high byte
    input wire logic [7:0] pointer_extension_reg, // Pointer extension
    input wire logic program_store_instr, // Store instruction pulse
    input wire logic program_load_instr, // Load instruction pulse
    output logic store_grant, // Programming started, pulse
    output logic store_deny, // Store refused, pulse
    output logic [31:0] prog_page, // Latched page number
    output logic [PAGE_WORD_BITS-1:0] prog_word, // Latched word in page
    output logic load_grant, // Load allowed, pulse
    output logic load_deny, // Load blocked, pulse
    output logic [31:0] load_word_addr, // Word address of load
    output logic load_byte_hi, // High byte of word selected
    output logic irq_enable, // Interrupts permitted
    output logic [31:0] reset_vector // Word address after reset
);

    localparam int ADDR_W = $clog2(PROG_BYTES);
    localparam int WORD_W = ADDR_W - 1;

    // Elaboration checks on the parameters
    generate
        if (PROG_BYTES < 1024 || (PROG_BYTES & (PROG_BYTES - 1)) != 0) begin : g_bad_size
            $error("PROG_BYTES must be a power of two, at least 1024");
        end
        if (PROG_BYTES > 16777216) begin : g_bad_ptr
            $error("PROG_BYTES exceeds the 24-bit pointer");
        end
        if (PAGE_WORD_BITS < 1 || PAGE_WORD_BITS >= WORD_W) begin : g_bad_page
            $error("PAGE_WORD_BITS out of range");
        end
        if (BOOT_MIN_WORDS * 8 > PROG_BYTES / 2) begin : g_bad_boot
            $error("BOOT_MIN_WORDS too large for the flash");
        end
    endgenerate

    logic [3:0] lock_q;
    logic ivec_boot_q;
    logic store_deny_flag_q;
    logic load_deny_flag_q;
    logic [31:0] prdata_q;
    logic store_grant_q;
    logic store_deny_q;
    logic load_grant_q;
    logic load_deny_q;
    logic [WORD_W-PAGE_WORD_BITS-1:0] page_q;
    logic [PAGE_WORD_BITS-1:0] word_q;
    logic [WORD_W-1:0] load_word_q;
    logic byte_hi_q;
    logic [31:0] reset_vec_q;
    logic [ADDR_W-1:0] ptr;
    logic [WORD_W-1:0] boot_start;
    section_e pc_sec;
    section_e tgt_sec;
    logic app_wr_open;
    logic app_rd_open;
    logic boot_wr_open;
    logic boot_rd_open;
    logic store_ok;
    logic load_ok;
    logic wr_en;
    logic rd_setup;
    logic addr_ok;

    // Pointer: extension byte only when flash exceeds 64 Kbytes
    generate
        if (ADDR_W > 16) begin : g_ext
            assign ptr = {pointer_extension_reg[ADDR_W-17:0], pointer_high_byte,
                pointer_low_byte};
        end else begin : g_noext
            logic [15:0] ptr16;
            assign ptr16 = {pointer_high_byte, pointer_low_byte};
            assign ptr = ptr16[ADDR_W-1:0];
        end
    endgenerate

    // Boundary compare for the executing code and the addressed word
    section_decoder #(
        .WORD_W(WORD_W),
        .BOOT_MIN_WORDS(BOOT_MIN_WORDS)
    ) u_pc_dec (
        .word_addr(pc[WORD_W-1:0]),
        .boot_size_fuses(boot_size_fuses),
        .boot_start(boot_start),
        .section(pc_sec)
    );

    section_decoder #(
        .WORD_W(WORD_W),
        .BOOT_MIN_WORDS(BOOT_MIN_WORDS)
    ) u_tgt_dec (
        .word_addr(ptr[ADDR_W-1:1]),
        .boot_size_fuses(boot_size_fuses),
        .boot_start(),
        .section(tgt_sec)
    );

    // Access permission from the lock fields and the PC and target sections
    always_comb begin
        app_wr_open = lock_q[`LK_APP_WR];
        app_rd_open = lock_q[`LK_APP_RD];
        boot_wr_open = lock_q[`LK_BOOT_WR];
        boot_rd_open = lock_q[`LK_BOOT_RD];
        // General lock modes take no part here
        store_ok = (pc_sec == SEC_BOOT) &&
            ((tgt_sec == SEC_APP) ? app_wr_open : boot_wr_open);
        load_ok = 1'b1;
        if (pc_sec == SEC_BOOT && tgt_sec == SEC_APP && !app_rd_open)
            load_ok = 1'b0;
        if (pc_sec == SEC_APP && tgt_sec == SEC_BOOT && !boot_rd_open)
            load_ok = 1'b0;
    end

    // Store handling and address latch
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            store_grant_q <= 1'b0;
            store_deny_q <= 1'b0;
            page_q <= '0;
            word_q <= '0;
        end else begin
            store_grant_q <= program_store_instr && store_ok;
            store_deny_q <= program_store_instr && !store_ok;
            if (program_store_instr && store_ok) begin
                page_q <= ptr[ADDR_W-1:PAGE_WORD_BITS+1];
                word_q <= ptr[PAGE_WORD_BITS:1];
            end
        end
    end

    // Load handling, byte addressed
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            load_grant_q <= 1'b0;
            load_deny_q <= 1'b0;
            load_word_q <= '0;
            byte_hi_q <= 1'b0;
        end else begin
            load_grant_q <= program_load_instr && load_ok;
            load_deny_q <= program_load_instr && !load_ok;
            if (program_load_instr && load_ok) begin
                load_word_q <= ptr[ADDR_W-1:1];
                byte_hi_q <= ptr[0];
            end
        end
    end

    // Interrupt gating when vectors sit in the other section
    always_comb begin
        irq_enable = 1'b1;
        if (!app_rd_open && ivec_boot_q && pc_sec == SEC_APP)
            irq_enable = 1'b0;
        if (!boot_rd_open && !ivec_boot_q && pc_sec == SEC_BOOT)
            irq_enable = 1'b0;
    end

    // Reset vector captured while reset is held
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            if (boot_reset_fuse)
                reset_vec_q <= `APP_RESET_VEC;
            else
                reset_vec_q <= 32'(boot_start);
        end
    end

    // APB decode
    always_comb begin
        wr_en = psel && penable && pwrite;
        rd_setup = psel && !penable && !pwrite;
        addr_ok = (paddr == `LOCK_OFS) || (paddr == `CTRL_OFS) ||
            (paddr == `STAT_OFS) || (paddr == `PTR_OFS);
    end

    // Lock field: writes may only program, erase restores; srst leaves it alone
    always_ff @(posedge ref_clk) begin
        if (chip_erase_req) begin
            lock_q <= `LOCK_RST;
        end else if (!srst) begin
            if (wr_en && paddr == `LOCK_OFS)
                lock_q <= lock_q & pwdata[3:0] &
                    (ext_lock_wr ? ext_lock_data : 4'hf);
            else if (ext_lock_wr)
                lock_q <= lock_q & ext_lock_data;
        end
    end

    // Vector placement control
    always_ff @(posedge ref_clk) begin
        if (srst)
            ivec_boot_q <= `CTRL_RST;
        else if (wr_en && paddr == `CTRL_OFS)
            ivec_boot_q <= pwdata[`CTRL_IVB];
    end

    // Sticky refusal flags, write one clears, set wins
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            store_deny_flag_q <= 1'b0;
            load_deny_flag_q <= 1'b0;
        end else begin
            if (store_deny_q)
                store_deny_flag_q <= 1'b1;
            else if (wr_en && paddr == `STAT_OFS && pwdata[`ST_STORE_DENY])
                store_deny_flag_q <= 1'b0;
            if (load_deny_q)
                load_deny_flag_q <= 1'b1;
            else if (wr_en && paddr == `STAT_OFS && pwdata[`ST_LOAD_DENY])
                load_deny_flag_q <= 1'b0;
        end
    end

    // Read data sampled in the setup cycle; fuses are read only
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            prdata_q <= '0;
        end else if (rd_setup) begin
            case (paddr)
                `LOCK_OFS: prdata_q <= {28'h0, lock_q};
                `CTRL_OFS: prdata_q <= {31'h0, ivec_boot_q};
                `STAT_OFS: prdata_q <= {26'h0, boot_size_fuses, boot_reset_fuse,
                    pc_sec == SEC_BOOT, load_deny_flag_q, store_deny_flag_q};
                `PTR_OFS: prdata_q <= 32'(ptr);
                default: prdata_q <= '0;
            endcase
        end
    end

    assign prdata = prdata_q;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_ok;
    assign store_grant = store_grant_q;
    assign store_deny = store_deny_q;
    assign prog_page = 32'(page_q);
    assign prog_word = word_q;
    assign load_grant = load_grant_q;
    assign load_deny = load_deny_q;
    assign load_word_addr = 32'(load_word_q);
    assign load_byte_hi = byte_hi_q;
    assign reset_vector = reset_vec_q;

    property p_store_from_app;
        @(posedge ref_clk) disable iff (srst)
        program_store_instr && pc_sec == SEC_APP |=> !store_grant && store_deny;
    endproperty
    a_store_from_app: assert property (p_store_from_app)
        else $error("store from application section was granted");

    property p_app_write;
        @(posedge ref_clk) disable iff (srst)
        program_store_instr && tgt_sec == SEC_APP && !lock_q[`LK_APP_WR]
        |=> !store_grant;
    endproperty
    a_app_write: assert property (p_app_write)
        else $error("store to locked application section granted");

    property p_boot_write;
        @(posedge ref_clk) disable iff (srst)
        program_store_instr && tgt_sec == SEC_BOOT && !lock_q[`LK_BOOT_WR]
        |=> !store_grant;
    endproperty
    a_boot_write: assert property (p_boot_write)
        else $error("store to locked boot section granted");

    property p_app_read;
        @(posedge ref_clk) disable iff (srst)
        program_load_instr && pc_sec == SEC_BOOT && tgt_sec == SEC_APP &&
        !lock_q[`LK_APP_RD] |=> load_deny && !load_grant;
    endproperty
    a_app_read: assert property (p_app_read)
        else $error("boot load of protected application granted");

    property p_boot_read;
        @(posedge ref_clk) disable iff (srst)
        program_load_instr && pc_sec == SEC_APP && tgt_sec == SEC_BOOT &&
        !lock_q[`LK_BOOT_RD] |=> load_deny && !load_grant;
    endproperty
    a_boot_read: assert property (p_boot_read)
        else $error("application load of protected boot granted");

    property p_open_load;
        @(posedge ref_clk) disable iff (srst)
        program_load_instr && lock_q == `LOCK_RST |=> load_grant && !load_deny;
    endproperty
    a_open_load: assert property (p_open_load)
        else $error("load refused with all lock bits open");

    property p_lock_sticky;
        @(posedge ref_clk) disable iff (srst)
        !chip_erase_req |=> (lock_q & ~$past(lock_q)) == 4'h0;
    endproperty
    a_lock_sticky: assert property (p_lock_sticky)
        else $error("lock bit returned to unprogrammed without erase");

    property p_latch;
        @(posedge ref_clk) disable iff (srst)
        !(program_store_instr && store_ok) |=> $stable(page_q) && $stable(word_q);
    endproperty
    a_latch: assert property (p_latch)
        else $error("latched address moved without a granted store");

    property p_irq_app;
        @(posedge ref_clk) disable iff (srst)
        !lock_q[`LK_APP_RD] && ivec_boot_q && pc_sec == SEC_APP |-> !irq_enable;
    endproperty
    a_irq_app: assert property (p_irq_app)
        else $error("interrupts enabled in read-protected application");

    property p_irq_boot;
        @(posedge ref_clk) disable iff (srst)
        !lock_q[`LK_BOOT_RD] && !ivec_boot_q && pc_sec == SEC_BOOT |-> !irq_enable;
    endproperty
    a_irq_boot: assert property (p_irq_boot)
        else $error("interrupts enabled in read-protected boot section");

    property p_reset_vec;
        @(posedge ref_clk)
        srst && boot_reset_fuse |=> reset_vector == `APP_RESET_VEC;
    endproperty
    a_reset_vec: assert property (p_reset_vec)
        else $error("reset vector not zero with fuse unprogrammed");

endmodule

// [bench/core_model.sv]
`timescale 1ns/1ps

module core_model (
    input wire logic ref_clk, // System clock
    output logic [14:0] pc, // Word program counter
    output logic [7:0] pointer_low_byte, // Pointer low byte
    output logic [7:0] pointer_high_byte, // Pointer high byte
    output logic [7:0] pointer_extension_reg, // Unused up to 64 Kbytes
    output logic program_store_instr, // Store pulse
    output logic program_load_instr // Load pulse
);
    initial begin
        pc = 15'h0000;
        pointer_low_byte = 8'h00;
        pointer_high_byte = 8'h00;
        pointer_extension_reg = 8'h00;
        program_store_instr = 1'b0;
        program_load_instr = 1'b0;
    end

    // One-cycle request, then pointer reused for other work
    task automatic access(input logic st, input logic [14:0] p, input logic [15:0] ptr);
        @(posedge ref_clk);
        pc <= p;
        pointer_high_byte <= ptr[15:8];
        pointer_low_byte <= ptr[7:0];
        program_store_instr <= st;
        program_load_instr <= ~st;
        @(posedge ref_clk);
        program_store_instr <= 1'b0;
        program_load_instr <= 1'b0;
        pointer_high_byte <= ~ptr[15:8];
        pointer_low_byte <= ~ptr[7:0];
    endtask

    // Move execution without an access
    task automatic set_pc(input logic [14:0] p);
        @(posedge ref_clk);
        pc <= p;
    endtask
endmodule

// [bench/boot_flash_lock_protection_tb.sv]
`timescale 1ns/1ps
`include "flash_prot_defs.svh"

module boot_flash_lock_protection_tb;
    import flash_prot_pkg::*;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr;
    logic boot_reset_fuse = 1'b0;
    logic [1:0] boot_size_fuses = 2'h3;
    logic chip_erase_req = 1'b1;
    logic ext_lock_wr = 1'b0;
    logic [3:0] ext_lock_data = 4'hf;
    logic [14:0] pc;
    logic [7:0] ptr_lo, ptr_hi, ptr_ext;
    logic st_i, ld_i, store_grant, store_deny, load_grant, load_deny, load_byte_hi;
    logic irq_enable;
    logic [31:0] prog_page, load_word_addr, reset_vector, rd;
    logic [6:0] prog_word;
    logic err;
    int n_errors = 0;
    int compares = 0;

    // Clock at 200 MHz
    always #2.5 ref_clk = ~ref_clk;

    core_model core_model_inst (.ref_clk(ref_clk), .pc(pc), .pointer_low_byte(ptr_lo),
        .pointer_high_byte(ptr_hi), .pointer_extension_reg(ptr_ext),
        .program_store_instr(st_i), .program_load_instr(ld_i));

    boot_flash_lock_protection boot_flash_lock_protection_inst (.ref_clk(ref_clk),
        .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .boot_reset_fuse(boot_reset_fuse), .boot_size_fuses(boot_size_fuses),
        .chip_erase_req(chip_erase_req), .ext_lock_wr(ext_lock_wr),
        .ext_lock_data(ext_lock_data), .pc(pc), .pointer_low_byte(ptr_lo),
        .pointer_high_byte(ptr_hi), .pointer_extension_reg(ptr_ext),
        .program_store_instr(st_i), .program_load_instr(ld_i), .store_grant(store_grant),
        .store_deny(store_deny), .prog_page(prog_page), .prog_word(prog_word),
        .load_grant(load_grant), .load_deny(load_deny), .load_word_addr(load_word_addr),
        .load_byte_hi(load_byte_hi), .irq_enable(irq_enable), .reset_vector(reset_vector));

    task automatic end_of_test;
        $display("Counts: %0d compares, %0d errors", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // APB transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int i;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge ref_clk);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (i == 20) begin
            n_errors++;
            end_of_test();
        end
    endtask

    // Core access; response pulses are seen one cycle later
    task automatic core(input logic st, input logic [14:0] p, input logic [15:0] ptr,
                        input logic [3:0] exp);
        core_model_inst.access(st, p, ptr);
        #1;
        check({28'h0, store_grant, store_deny, load_grant, load_deny}, {28'h0, exp});
    endtask

    task automatic pulse_lock(input logic erase, input logic [3:0] d);
        @(posedge ref_clk);
        chip_erase_req <= erase;
        ext_lock_wr <= ~erase;
        ext_lock_data <= d;
        @(posedge ref_clk);
        chip_erase_req <= 1'b0;
        ext_lock_wr <= 1'b0;
    endtask

    task automatic do_reset(input logic fuse, input logic [31:0] exp_vec);
        @(posedge ref_clk);
        srst <= 1'b1;
        boot_reset_fuse <= fuse;
        repeat (2) @(posedge ref_clk);
        srst <= 1'b0;
        chip_erase_req <= 1'b0;
        #1;
        check(reset_vector, exp_vec);
    endtask

    task automatic irq_at(input logic [14:0] p, input logic exp);
        core_model_inst.set_pc(p);
        #1;
        check({31'h0, irq_enable}, {31'h0, exp});
    endtask

    initial begin
        // Boot start with 512 boot words is word 0x7e00
        do_reset(1'b0, 32'h0000_7e00);
        pulse_lock(1'b1, 4'hf);
        core(1'b1, 15'h7e00, 16'h1234, 4'b1000);
        check(prog_page, 32'h12);
        check({25'h0, prog_word}, 32'h1a);
        @(posedge ref_clk);
        #1;
        check(prog_page, 32'h12);
        core(1'b0, 15'h0100, 16'hfc03, 4'b0010);
        check(load_word_addr, 32'h7e01);
        check({31'h0, load_byte_hi}, 32'h1);
        core(1'b1, 15'h0100, 16'h1234, 4'b0100);
        $display("Test open locks done");
        pulse_lock(1'b0, 4'he);
        core(1'b1, 15'h7e00, 16'h1234, 4'b0100);
        core(1'b1, 15'h7e00, 16'hfc00, 4'b1000);
        core(1'b0, 15'h7e00, 16'h1234, 4'b0010);
        apb(1'b1, `LOCK_OFS, 32'hffff_ffff);
        apb(1'b0, `LOCK_OFS, 32'h0);
        check(rd, 32'he);
        apb(1'b1, `LOCK_OFS, 32'hffff_fff3);
        core(1'b1, 15'h7e00, 16'hfc00, 4'b0100);
        core(1'b0, 15'h0100, 16'hfc03, 4'b0001);
        core(1'b0, 15'h7e10, 16'hfc03, 4'b0010);
        irq_at(15'h7e10, 1'b0);
        irq_at(15'h0100, 1'b1);
        $display("Test lock modes done");
        pulse_lock(1'b1, 4'h0);
        apb(1'b0, `LOCK_OFS, 32'h0);
        check(rd, 32'hf);
        pulse_lock(1'b0, 4'hd);
        core(1'b0, 15'h7e00, 16'h1234, 4'b0001);
        core(1'b1, 15'h7e00, 16'h1234, 4'b1000);
        apb(1'b1, `CTRL_OFS, 32'h1);
        irq_at(15'h0100, 1'b0);
        irq_at(15'h7e00, 1'b1);
        $display("Test read locks done");
        apb(1'b0, 8'h10, 32'h0);
        check({31'h0, err}, 32'h1);
        check(rd, 32'h0);
        do_reset(1'b1, 32'h0);
        @(posedge ref_clk);
        boot_size_fuses <= 2'h0;
        core(1'b1, 15'h0100, 16'h1234, 4'b0100);
        core(1'b1, 15'h7000, 16'h1234, 4'b1000);
        apb(1'b0, `STAT_OFS, 32'h0);
        check({28'h0, rd[5:2]}, 32'h3);
        check({30'h0, rd[1:0]}, 32'h1);
        apb(1'b0, `PTR_OFS, 32'h0);
        check(rd, 32'h0000_edcb);
        apb(1'b1, `STAT_OFS, 32'hffff_ffff);
        apb(1'b0, `STAT_OFS, 32'h0);
        check({31'h0, rd[3]}, 32'h1);
        check({30'h0, rd[1:0]}, 32'h0);
        $display("Test fuses done");
        end_of_test();
    end
endmodule
